// file: acc_pkg.sv
// Package of constants and types for the converter control block
// Notes on behaviour
// - Start bit write while enabled begins conversion
// - Hardware clears start bit at conversion end
// - Start bit reads one while converting
// - Enable bit one powers converter on
// - Codes 00000..00111 route external inputs 0..7
// - Codes 01001..11100 reserved, no input
// - 11101 temperature, 11110 DAC, 11111 reference buffer
// - Bit seven unimplemented, reads zero
// - Finish clears start, sets flag, loads result
// - Abort loads partial result, fills last bit
package acc_pkg;
    // Register byte addresses
    localparam logic [7:0] ACC_ADDR_CONTROL_0 = 8'h00;
    localparam logic [7:0] ACC_ADDR_RESULT_HI = 8'h04;
    localparam logic [7:0] ACC_ADDR_RESULT_LO = 8'h08;
    localparam logic [7:0] ACC_ADDR_STATUS    = 8'h0c;
    // Control field positions
    localparam int ACC_BIT_ENABLE = 0;
    localparam int ACC_BIT_START  = 1;
    localparam int ACC_CHS_LSB    = 2;
    localparam int ACC_CHS_MSB    = 6;
    localparam logic [7:0] ACC_CONTROL_RESET = 8'h00;
    // Channel codes
    localparam logic [4:0] ACC_CHS_EXT_LAST = 5'h07;
    localparam logic [4:0] ACC_CHS_TEMP     = 5'h1d;
    localparam logic [4:0] ACC_CHS_DAC      = 5'h1e;
    localparam logic [4:0] ACC_CHS_FVR      = 5'h1f;
    // Conversion sizing: 10 bits, one bit per tick of the conversion divider
    localparam int          ACC_RES_BITS  = 10;
    localparam logic [3:0]  ACC_BIT_LAST  = 4'h9;
    localparam logic [3:0]  ACC_TICK_DIV  = 4'h7;
    localparam logic [9:0]  ACC_RESULT_RESET = 10'h000;
    // Sequencer states: idle, converting, done
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_DONE = 2'b11
    } acc_state_t;
endpackage

// file: acc_sar.sv
// Successive-approximation register stepping one bit per tick
`timescale 1ns/100ps
`default_nettype none
module acc_sar (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // Control
    input  wire logic       load,
    input  wire logic       step,
    input  wire logic       cmp_high,
    input  wire logic [3:0] bit_idx,
    // Result
    output logic [9:0]      trial,
    output logic [9:0]      partial
);
    import acc_pkg::*;

    logic [9:0] mask;

    // Trial bit under test
    always_comb begin
        mask = 10'h001 << bit_idx;
    end

    // Kept bits, then trial bit set for the comparator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial <= ACC_RESULT_RESET;
        end else if (clk_en) begin
            if (load) begin
                trial <= 10'h200;
            end else if (step) begin
                trial <= (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
            end
        end
    end

    // Partial result: decided bits, lower bits copy the last decided bit
    always_comb begin
        partial = trial & ~((mask << 1) - 10'h001);
        if (bit_idx != ACC_BIT_LAST) begin
            partial = partial | ((trial[bit_idx + 4'h1]) ? ((mask << 1) - 10'h001)
                                                        : 10'h000);
        end
    end
endmodule
`default_nettype wire

// file: acc_top.sv
// Converter control register, sequencer and result holding
`timescale 1ns/100ps
`default_nettype none
module acc_top (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog front end
    input  wire logic        cmp_in,
    output logic             analog_power,
    output logic             sample_hold,
    output logic [3:0]       route_external,
    output logic             route_temp,
    output logic             route_dac,
    output logic             route_fvr,
    output logic [9:0]       dac_trial,
    // Completion event
    output logic             conversion_done_flag
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    acc_state_t state;
    logic       converter_enable;
    logic       start_status_bit_alias;
    logic [4:0] input_channel_select;
    logic [9:0] result;
    logic [3:0] bit_idx;
    logic [3:0] tick;
    logic       cmp_s1;
    logic       cmp_s2;
    logic [9:0] trial;
    logic [9:0] partial;
    logic       wr;
    logic       rd;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       go_req;
    logic       abort_req;
    logic       tick_hit;
    logic       last_step;

    // APB decode: writes in access phase, reads in setup; slave answers in the first access cycle
    assign wr       = psel && penable && pwrite;
    assign rd       = psel && !penable && !pwrite;
    assign wr_ctrl  = wr && (paddr == ACC_ADDR_CONTROL_0);
    assign wr_stat  = wr && (paddr == ACC_ADDR_STATUS);
    // Start only when already enabled, so start with enable in one write is ignored
    assign go_req   = wr_ctrl && pwdata[ACC_BIT_START] && converter_enable
                      && pwdata[ACC_BIT_ENABLE] && (state == ACC_IDLE);
    assign abort_req = wr_ctrl && !pwdata[ACC_BIT_START] && (state == ACC_CONV);
    assign tick_hit  = (tick == ACC_TICK_DIV);
    assign last_step = tick_hit && (bit_idx == 4'h0);

    // ------------------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------------------
    // Comparator is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else if (clk_en) begin
            cmp_s1 <= cmp_in;
            cmp_s2 <= cmp_s1;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Bit 7 not stored, so it can never read back as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable     <= ACC_CONTROL_RESET[ACC_BIT_ENABLE];
            input_channel_select <= ACC_CONTROL_RESET[ACC_CHS_MSB:ACC_CHS_LSB];
        end else if (clk_en && wr_ctrl) begin
            converter_enable     <= pwdata[ACC_BIT_ENABLE];
            input_channel_select <= pwdata[ACC_CHS_MSB:ACC_CHS_LSB];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Disabling the converter mid-conversion ends it; the partial result is loaded only if start is also written zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                  <= ACC_IDLE;
            start_status_bit_alias <= 1'b0;
            bit_idx                <= ACC_BIT_LAST;
            tick                   <= 4'h0;
        end else if (clk_en) begin
            case (state)
                ACC_IDLE: begin
                    tick    <= 4'h0;
                    bit_idx <= ACC_BIT_LAST;
                    if (go_req) begin
                        state                  <= ACC_CONV;
                        start_status_bit_alias <= 1'b1;
                    end
                end
                ACC_CONV: begin
                    if (abort_req || (wr_ctrl && !pwdata[ACC_BIT_ENABLE])) begin
                        state                  <= ACC_IDLE;
                        start_status_bit_alias <= 1'b0;
                    end else if (last_step) begin
                        state                  <= ACC_DONE;
                        start_status_bit_alias <= 1'b0;
                    end else if (tick_hit) begin
                        tick    <= 4'h0;
                        bit_idx <= bit_idx - 4'h1;
                    end else begin
                        tick <= tick + 4'h1;
                    end
                end
                ACC_DONE: begin
                    state <= ACC_IDLE;
                end
                default: begin
                    state                  <= ACC_IDLE;
                    start_status_bit_alias <= 1'b0;
                end
            endcase
        end
    end

    // SAR stepping
    acc_sar u_sar (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .load     (go_req),
        .step     (state == ACC_CONV && tick_hit),
        .cmp_high (cmp_s2),
        .bit_idx  (bit_idx),
        .trial    (trial),
        .partial  (partial)
    );

    // ------------------------------------------------------------
    // Result and done flag
    // ------------------------------------------------------------
    // Final compare decides bit 0; abort keeps the filled partial value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= ACC_RESULT_RESET;
        end else if (clk_en) begin
            if (state == ACC_CONV && last_step) begin
                result <= cmp_s2 ? trial : (trial & ~10'h001);
            end else if (abort_req) begin
                result <= partial;
            end
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_flag <= 1'b0;
        end else if (clk_en) begin
            if (state == ACC_CONV && last_step) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_stat && pwdata[0]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Analog outputs
    // ------------------------------------------------------------
    // Registered routing; reserved codes drive nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_power   <= 1'b0;
            sample_hold    <= 1'b0;
            route_external <= 4'h0;
            route_temp     <= 1'b0;
            route_dac      <= 1'b0;
            route_fvr      <= 1'b0;
            dac_trial      <= ACC_RESULT_RESET;
        end else if (clk_en) begin
            analog_power   <= converter_enable;
            sample_hold    <= (state == ACC_CONV);
            dac_trial      <= trial;
            route_external <= 4'h0;
            if (converter_enable && input_channel_select <= ACC_CHS_EXT_LAST) begin
                route_external <= {1'b1, input_channel_select[2:0]};
            end
            route_temp <= converter_enable && (input_channel_select == ACC_CHS_TEMP);
            route_dac  <= converter_enable && (input_channel_select == ACC_CHS_DAC);
            route_fvr  <= converter_enable && (input_channel_select == ACC_CHS_FVR);
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    // Read data registered in setup, valid through access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == ACC_ADDR_CONTROL_0 ||
                       paddr == ACC_ADDR_RESULT_HI || paddr == ACC_ADDR_RESULT_LO ||
                       paddr == ACC_ADDR_STATUS);
            if (rd) begin
                case (paddr)
                    ACC_ADDR_CONTROL_0: prdata <= {24'h0, 1'b0, input_channel_select,
                                              start_status_bit_alias, converter_enable};
                    ACC_ADDR_RESULT_HI: prdata <= {24'h0, result[9:2]};
                    ACC_ADDR_RESULT_LO: prdata <= {24'h0, result[1:0], 6'h00};
                    ACC_ADDR_STATUS:    prdata <= {31'h0, conversion_done_flag};
                    default:            prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: acc_top_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acc_checker
    import acc_pkg::*;
(
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Analog front end
    input wire logic        analog_power,
    input wire logic        sample_hold,
    input wire logic [3:0]  route_external,
    input wire logic        route_temp,
    input wire logic        route_dac,
    input wire logic        route_fvr,
    input wire logic        conversion_done_flag
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic       ctl_wr;
    logic       last_en;
    logic [4:0] last_chs;
    logic [7:0] busy_cnt;
    assign ctl_wr = psel && penable && pwrite && paddr == ACC_ADDR_CONTROL_0;
    // Last written control fields, so checks two cycles on see the cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_en  <= 1'b0;
            last_chs <= 5'h00;
        end else if (ctl_wr) begin
            last_en  <= pwdata[0];
            last_chs <= pwdata[6:2];
        end
    end
    // Saturating run length; a stuck sequencer shows up here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_cnt <= 8'h00;
        else if (!sample_hold) busy_cnt <= 8'h00;
        else if (busy_cnt != 8'hff) busy_cnt <= busy_cnt + 8'h01;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    enable_follow_a: assert property (ctl_wr |-> ##2 analog_power == last_en)
        else $error("enable output differs from written bit");
    start_begin_a: assert property (ctl_wr && pwdata[1:0] == 2'b11 && analog_power
        && !sample_hold |-> ##2 sample_hold) else $error("start did not begin conversion");
    conv_bound_a: assert property (busy_cnt <= 8'd100)
        else $error("conversion never ended");
    off_idle_a: assert property (!analog_power && !$past(analog_power) |-> !sample_hold)
        else $error("converting while disabled");
    route_ext_a: assert property (ctl_wr && pwdata[0] |-> ##2 route_external ==
        (last_chs <= 5'h07 ? {1'b1, last_chs[2:0]} : 4'h0)) else $error("external route wrong");
    route_rsv_a: assert property (ctl_wr && pwdata[0] && pwdata[6:2] inside {[5'd9:5'd28]}
        |-> ##2 !(route_external[3] | route_temp | route_dac | route_fvr))
        else $error("reserved code routed an input");
    route_spec_a: assert property (ctl_wr && pwdata[0] |-> ##2 {route_temp, route_dac,
        route_fvr} == {last_chs == 5'h1d, last_chs == 5'h1e, last_chs == 5'h1f})
        else $error("internal route wrong");
    bit7_zero_a: assert property (psel && penable && pready && !pwrite
        && paddr == ACC_ADDR_CONTROL_0 |-> prdata[7] == 1'b0) else $error("bit seven read one");
    reset_clear_a: assert property ($rose(presetn) |-> !analog_power && !sample_hold
        && route_external == 4'h0) else $error("outputs not cleared by reset");
    // Main scenarios reached
    cover property (ctl_wr && pwdata[1:0] == 2'b11);
    cover property ($fell(sample_hold) && analog_power);
    cover property ($rose(conversion_done_flag));
endmodule
bind acc_top acc_checker acc_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .analog_power(analog_power), .sample_hold(sample_hold),
    .route_external(route_external), .route_temp(route_temp), .route_dac(route_dac),
    .route_fvr(route_fvr), .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// file: acc_top_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acc_top_bench;
    import acc_pkg::*;
    // ----------------------------------------
    // Signals and instance
    // ----------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, cmp_in, pready, pslverr, err_seen;
    logic        analog_power, sample_hold, route_temp, route_dac, route_fvr, done_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  route_external;
    logic [9:0]  dac_trial, target;
    int          error_cnt, checks_done;
    localparam logic [7:0] CTL = ACC_ADDR_CONTROL_0;
    acc_top acc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .analog_power(analog_power),
        .sample_hold(sample_hold), .route_external(route_external), .route_temp(route_temp),
        .route_dac(route_dac), .route_fvr(route_fvr), .dac_trial(dac_trial),
        .conversion_done_flag(done_flag));
    // Clock, and a comparator whose input sits half a step above target
    always #20 pclk = ~pclk;
    always @(posedge pclk) cmp_in <= (target >= dac_trial);
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Read right after the edge: registered outputs still show edge values
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(s, e, q);
    endtask
    // Start, optionally abort, poll to idle, compare the result
    task automatic convert(input logic [9:0] t, input int abort_at, input logic [9:0] e);
        logic [31:0] q;
        int n;
        target = t;
        n = 0;
        wr(CTL, 32'h01);
        repeat (4) @(posedge pclk); // acquisition wait
        wr(CTL, 32'h03);
        rd_chk("busy", CTL, 32'h03);
        if (abort_at > 0) begin
            repeat (abort_at) @(posedge pclk);
            wr(CTL, 32'h01);
        end
        do begin
            apb(1'b0, CTL, 32'h0, q);
            n++;
        end while (q[1] !== 1'b0 && n < 60);
        chk("status", 32'h01, q);
        rd_chk("res_hi", ACC_ADDR_RESULT_HI, {24'h0, e[9:2]});
        rd_chk("res_lo", ACC_ADDR_RESULT_LO, {24'h0, e[1:0], 6'h0});
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        target = 10'h000;
        error_cnt = 0;
        checks_done = 0;
        // Pin direction and analog select live outside this block
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", CTL, 32'h0);
        rd_chk("res_hi", ACC_ADDR_RESULT_HI, 32'h0);
        rd_chk("flag", ACC_ADDR_STATUS, 32'h0);
        chk("slverr", 32'h0, {31'h0, err_seen});
        rd_chk("unmapped", 8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, err_seen});
        wr(CTL, 32'h02); // start refused while disabled
        rd_chk("ctrl", CTL, 32'h0);
        wr(CTL, 32'h81);
        rd_chk("ctrl", CTL, 32'h01);
        chk("power", 32'h1, {31'h0, analog_power});
        // Every documented selector code, 01000 has no meaning
        for (int c = 0; c < 32; c++) begin
            if (c == 8) continue;
            wr(CTL, {25'h0, c[4:0], 2'b01});
            repeat (2) @(posedge pclk);
            chk("route", {25'h0, (c < 8) ? {1'b1, c[2:0]} : 4'h0, c == 29, c == 30, c == 31},
                {25'h0, route_external, route_temp, route_dac, route_fvr});
            rd_chk("ctrl", CTL, {25'h0, c[4:0], 2'b01});
        end
        wr(ACC_ADDR_STATUS, 32'h1);
        convert(10'h2c5, 0, 10'h2c5);
        rd_chk("flag", ACC_ADDR_STATUS, 32'h1);
        chk("done", 32'h1, {31'h0, done_flag});
        wr(ACC_ADDR_STATUS, 32'h1);
        rd_chk("flag", ACC_ADDR_STATUS, 32'h0);
        chk("done", 32'h0, {31'h0, done_flag});
        convert(10'h3fe, 24, 10'h3ff); // undecided bits copy a one
        // Restart, then switch off mid-conversion
        wr(CTL, 32'h03);
        wr(CTL, 32'h00);
        repeat (2) @(posedge pclk);
        chk("power", 32'h0, {31'h0, analog_power});
        chk("busy", 32'h0, {31'h0, sample_hold});
        rd_chk("ctrl", CTL, 32'h0);
        // Reset in mid-conversion
        wr(CTL, 32'h01);
        wr(CTL, 32'h03);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", CTL, 32'h0);
        chk("busy", 32'h0, {31'h0, sample_hold});
        end_of_test;
    end
    // Watchdog well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test;
    end
endmodule
`default_nettype wire
